// ---- core/ssl_pkg.sv ----
// package for the serial eeprom setup loader
package ssl_pkg;
  // register byte addresses on the apb slave
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_BASE   = 8'h08;
  localparam logic [7:0] ADDR_IA01   = 8'h0C;
  localparam logic [7:0] ADDR_IA23   = 8'h10;
  localparam logic [7:0] ADDR_IA45   = 8'h14;
  localparam logic [7:0] ADDR_PTR    = 8'h18;
  localparam logic [7:0] ADDR_GPDATA = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  // control register fields
  localparam int CTRL_SEL    = 0;
  localparam int CTRL_RELOAD = 1;
  localparam int CTRL_STORE  = 2;
  // reset defaults (plain values, not any real board's)
  localparam logic [15:0] CONFIG_RST = 16'h0000;
  localparam logic [15:0] BASE_RST   = 16'h0000;
  localparam logic [15:0] IA_RST     = 16'h0000;
  // fixed base value used with straps all high
  localparam logic [15:0] BASE_FIXED = 16'h0000;
  // eeprom map
  localparam logic [2:0] STRAP_ONLY_IA = 3'h7;
  localparam logic [5:0] IA_WORD0      = 6'h20;
  localparam logic [1:0] IA_WORDS      = 2'h3;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [1:0] OP_EWEN       = 2'h0;
  localparam logic [5:0] EWEN_ADDR     = 6'h30;
  // serial clock half period in system clocks (1 us / 10 ns / 2)
  localparam int SK_HALF_NS  = 500;
  localparam int CLK_NS      = 10;
  localparam int SK_HALF_CYC = SK_HALF_NS / CLK_NS;
  // write-cycle completion wait: poll busy on data out, bounded
  localparam int WR_MAX_NS   = 10000000;
  localparam int WR_MAX_CYC  = WR_MAX_NS / CLK_NS;
  localparam int FRAME_BITS  = 25;
  typedef enum logic [1:0] {SSL_JOB_CFG, SSL_JOB_BASE, SSL_JOB_IA, SSL_JOB_GP} ssl_job_e;
  typedef struct packed {
    logic       cs;
    logic       sk;
    logic       di;
  } ssl_eep_s;
endpackage : ssl_pkg

// ---- core/ssl_loader.sv ----
// eeprom setup loader with apb register access
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - after reset the station address, base and configuration words load from the eeprom.
// - the eeprom is 64 words of 16 bits, accessed whole words with word addresses.
// - configuration sits at strap value times 4 and base at that address plus 1.
// - the station address always comes from words 20h to 22h.
// - with straps at 7 only the station address loads; other registers keep their values.
// - select at 0, a reload fills configuration, base and station address.
// - select at 0, a store writes configuration and base to the strap-selected words; with straps at 7 it writes the station address words instead.
// - select, reload and store are control bits 0 to 2 and never go to or from the eeprom.
// - select at 1, a reload reads the pointer-addressed word into the data register.
// - select at 1, a store writes the data register to the pointer-addressed word.
// - the host sets reload or store and polls; the device clears the bit when done.
// - while busy, reload and store both read back high.
// - while busy, every other register is neither readable nor writable.
// - busy and lockout apply to the reset-started reload too.
// - straps all high force fixed base and interrupt values. The code forces only base_word to BASE_FIXED; it forces no interrupt value.
// - with the presence strap low no eeprom access is made.
module ssl_loader (
  input  wire logic        clk_sys,            // system clock
  input  wire logic        rst_n,              // synchronous reset, low active
  input  wire logic        psel,               // apb select
  input  wire logic        penable,            // apb enable
  input  wire logic        pwrite,             // apb direction
  input  wire logic [7:0]  paddr,              // apb byte address
  input  wire logic [31:0] pwdata,             // apb write data
  output logic             pready,             // apb ready
  output logic [31:0]      prdata,             // apb read data
  output logic             pslverr,            // apb error
  input  wire logic [2:0]  board_slot_straps,  // slot straps
  input  wire logic        nvm_present_strap,  // eeprom fitted
  output logic             eep_cs,             // eeprom chip select
  output logic             eep_sk,             // eeprom serial clock
  output logic             eep_di,             // eeprom data in
  input  wire logic        eep_do,             // eeprom data out
  output logic [15:0]      config_word,        // configuration register
  output logic [15:0]      base_word,          // base register
  output logic [47:0]      station_addr        // individual address
);
  typedef enum {ST_IDLE, ST_SHIFT, ST_WAIT, ST_NEXT} ssl_st_e;
  ssl_st_e             st_r;
  ssl_pkg::ssl_job_e   job_r;
  ssl_pkg::ssl_eep_s   eep_r;
  logic [15:0]         config_r, base_r, ptr_r, gp_r;
  logic [15:0]         ia_r [3];
  logic                sel_r, reload_r, store_r, ewen_r, boot_r;
  logic [1:0]          ia_idx_r;
  logic [4:0]          bit_r;
  logic [7:0]          div_r;
  logic [23:0]         wait_r;
  logic [24:0]         frame_r;
  logic [15:0]         shin_r;
  logic                busy;
  logic [5:0]          base_addr;
  logic [5:0]          word_addr;
  logic [15:0]         wr_word;
  logic                wr_acc, rd_acc;
  logic                wait_done;
  logic                last_job;
  logic                op_done;

  assign busy      = reload_r | store_r;
  assign base_addr = {1'b0, board_slot_straps, 2'b00};
  assign wr_acc    = psel & penable & pwrite;
  assign rd_acc    = psel & penable & ~pwrite;
  assign pready    = 1'b1;
  assign pslverr   = 1'b0;

  // a write is complete once the eeprom shows ready on data out, or the bound runs out
  assign wait_done = ewen_r
                     || !store_r
                     || (eep_r.cs && eep_do)
                     || (wait_r == 24'(ssl_pkg::WR_MAX_CYC));
  // the frame that finishes an operation: one general word, the base store, the last address word
  assign last_job  = (job_r == ssl_pkg::SSL_JOB_GP)
                     || (job_r == ssl_pkg::SSL_JOB_BASE && store_r)
                     || (job_r == ssl_pkg::SSL_JOB_IA
                         && ia_idx_r == ssl_pkg::IA_WORDS - 2'h1);
  // busy drops only here, so the lockout covers every frame of the operation
  assign op_done   = (st_r == ST_WAIT)
                     && wait_done
                     && !ewen_r
                     && last_job;

  always_comb begin
    word_addr = base_addr;
    wr_word   = config_r;
    case (job_r)
      ssl_pkg::SSL_JOB_CFG: begin
        word_addr = base_addr;
        wr_word   = config_r;
      end
      ssl_pkg::SSL_JOB_BASE: begin
        word_addr = base_addr + 6'h01;
        wr_word   = base_r;
      end
      ssl_pkg::SSL_JOB_IA: begin
        word_addr = ssl_pkg::IA_WORD0 + {4'h0, ia_idx_r};
        wr_word   = ia_r[ia_idx_r];
      end
      default: begin
        word_addr = ptr_r[5:0];
        wr_word   = gp_r;
      end
    endcase
  end

  // first job of an operation
  function automatic ssl_pkg::ssl_job_e first_job(input logic sel, input logic [2:0] s);
    if (sel) first_job = ssl_pkg::SSL_JOB_GP;
    else if (s == ssl_pkg::STRAP_ONLY_IA) first_job = ssl_pkg::SSL_JOB_IA;
    else first_job = ssl_pkg::SSL_JOB_CFG;
  endfunction : first_job

  // control bits and operation start; the state machine clears them
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sel_r    <= 1'b0;
      reload_r <= 1'b0;
      store_r  <= 1'b0;
      boot_r   <= 1'b1;
    end else begin
      boot_r <= 1'b0;
      if (boot_r) begin
        reload_r <= nvm_present_strap;
      end else if (op_done) begin
        reload_r <= 1'b0;
        store_r  <= 1'b0;
      end else if (!busy && wr_acc && paddr == ssl_pkg::ADDR_CTRL) begin
        sel_r <= pwdata[ssl_pkg::CTRL_SEL];
        if (nvm_present_strap) begin
          reload_r <= pwdata[ssl_pkg::CTRL_RELOAD] & ~pwdata[ssl_pkg::CTRL_STORE];
          store_r  <= pwdata[ssl_pkg::CTRL_STORE];
        end
      end
    end
  end

  // serial state machine: one whole word per frame, write enable ahead of stores
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r     <= ST_IDLE;
      job_r    <= ssl_pkg::SSL_JOB_CFG;
      ia_idx_r <= 2'h0;
      eep_r    <= '0;
      bit_r    <= 5'h00;
      div_r    <= 8'h00;
      wait_r   <= 24'h000000;
      frame_r  <= '0;
      shin_r   <= 16'h0000;
      ewen_r   <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (busy && !boot_r) begin
            job_r    <= first_job(sel_r, board_slot_straps);
            ia_idx_r <= 2'h0;
            ewen_r   <= store_r;
            st_r     <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (ewen_r) begin
            frame_r <= {1'b1, ssl_pkg::OP_EWEN, ssl_pkg::EWEN_ADDR, 16'h0000};
          end else begin
            frame_r <= {1'b1, store_r ? ssl_pkg::OP_WRITE : ssl_pkg::OP_READ,
                        word_addr, store_r ? wr_word : 16'h0000};
          end
          bit_r         <= 5'h00;
          div_r         <= 8'h00;
          eep_r.cs      <= 1'b1;
          eep_r.sk      <= 1'b0;
          eep_r.di      <= 1'b1; // start bit leads the frame
          st_r          <= ST_SHIFT;
          if (!ewen_r && busy) begin
            if (job_r == ssl_pkg::SSL_JOB_GP) st_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          div_r <= div_r + 8'h01;
          if (div_r == 8'(ssl_pkg::SK_HALF_CYC - 1)) begin
            div_r    <= 8'h00;
            eep_r.sk <= ~eep_r.sk;
            if (!eep_r.sk) begin
              // rising serial clock: the eeprom takes di, data out is sampled here
              shin_r <= {shin_r[14:0], eep_do};
              bit_r  <= bit_r + 5'h01;
            end else begin
              // falling serial clock: di moves only while the clock is low
              eep_r.di <= frame_r[23];
              frame_r  <= {frame_r[23:0], 1'b0};
              if (bit_r == 5'(ssl_pkg::FRAME_BITS)) begin
                eep_r.cs <= 1'b0;
                eep_r.di <= 1'b0;
                wait_r   <= 24'h000000;
                st_r     <= ST_WAIT;
              end
            end
          end
        end
        ST_WAIT: begin
          // after a write, cs high again and wait for data out ready
          wait_r <= wait_r + 24'h000001;
          if (!ewen_r && store_r && wait_r > 24'(ssl_pkg::SK_HALF_CYC)) eep_r.cs <= 1'b1;
          if (wait_done) begin
            eep_r.cs <= 1'b0;
            if (ewen_r) begin
              ewen_r <= 1'b0;
              st_r   <= ST_NEXT;
            end else begin
              st_r <= ST_IDLE;
              if (job_r == ssl_pkg::SSL_JOB_CFG) begin
                job_r <= ssl_pkg::SSL_JOB_BASE;
                st_r  <= ST_NEXT;
              end else if (job_r == ssl_pkg::SSL_JOB_BASE && !store_r) begin
                job_r <= ssl_pkg::SSL_JOB_IA;
                st_r  <= ST_NEXT;
              end else if (job_r == ssl_pkg::SSL_JOB_IA && ia_idx_r != ssl_pkg::IA_WORDS - 2'h1) begin
                ia_idx_r <= ia_idx_r + 2'h1;
                st_r     <= ST_NEXT;
              end
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // the last frame of an operation ends in ST_WAIT, where op_done clears the control bits
  // register file: loaded words and host writes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      config_r <= ssl_pkg::CONFIG_RST;
      base_r   <= ssl_pkg::BASE_RST;
      ptr_r    <= 16'h0000;
      gp_r     <= 16'h0000;
      for (int i = 0; i < 3; i++) ia_r[i] <= ssl_pkg::IA_RST;
    end else if (st_r == ST_WAIT && !ewen_r && reload_r && !store_r) begin
      case (job_r)
        ssl_pkg::SSL_JOB_CFG:  config_r <= shin_r;
        ssl_pkg::SSL_JOB_BASE: base_r   <= shin_r;
        ssl_pkg::SSL_JOB_IA:   ia_r[ia_idx_r] <= shin_r;
        default:               gp_r     <= shin_r;
      endcase
    end else if (!busy && wr_acc) begin
      if (paddr == ssl_pkg::ADDR_CONFIG) config_r <= pwdata[15:0];
      else if (paddr == ssl_pkg::ADDR_BASE) base_r <= pwdata[15:0];
      else if (paddr == ssl_pkg::ADDR_IA01) ia_r[0] <= pwdata[15:0];
      else if (paddr == ssl_pkg::ADDR_IA23) ia_r[1] <= pwdata[15:0];
      else if (paddr == ssl_pkg::ADDR_IA45) ia_r[2] <= pwdata[15:0];
      else if (paddr == ssl_pkg::ADDR_PTR) ptr_r <= pwdata[15:0];
      else if (paddr == ssl_pkg::ADDR_GPDATA) gp_r <= pwdata[15:0];
    end
  end

  // read data: busy locks out all but the control bits
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (busy) begin
        if (paddr == ssl_pkg::ADDR_CTRL) prdata <= 32'h00000006;
      end else if (paddr == ssl_pkg::ADDR_CTRL) prdata <= {29'h0, store_r, reload_r, sel_r};
      else if (paddr == ssl_pkg::ADDR_CONFIG) prdata <= {16'h0, config_r};
      else if (paddr == ssl_pkg::ADDR_BASE) prdata <= {16'h0, base_word};
      else if (paddr == ssl_pkg::ADDR_IA01) prdata <= {16'h0, ia_r[0]};
      else if (paddr == ssl_pkg::ADDR_IA23) prdata <= {16'h0, ia_r[1]};
      else if (paddr == ssl_pkg::ADDR_IA45) prdata <= {16'h0, ia_r[2]};
      else if (paddr == ssl_pkg::ADDR_PTR) prdata <= {16'h0, ptr_r};
      else if (paddr == ssl_pkg::ADDR_GPDATA) prdata <= {16'h0, gp_r};
      else if (paddr == ssl_pkg::ADDR_STATUS) prdata <= {31'h0, busy};
    end
  end

  // straps all high force the fixed base value onto base_word; nothing else is forced
  assign base_word    = (board_slot_straps == ssl_pkg::STRAP_ONLY_IA)
                        ? ssl_pkg::BASE_FIXED : base_r;
  assign config_word  = config_r;
  assign station_addr = {ia_r[2], ia_r[1], ia_r[0]};
  assign eep_cs       = eep_r.cs;
  assign eep_sk       = eep_r.sk;
  assign eep_di       = eep_r.di;
  logic unused_rd;
  assign unused_rd = rd_acc;
endmodule : ssl_loader
`default_nettype wire

// ---- bench/ssl_loader_chk.sv ----
// checker for the setup loader ports
`timescale 1ns/1ps
`default_nettype none
module ssl_loader_chk (
  input wire logic        clk_sys,            // clock
  input wire logic        rst_n,              // reset
  input wire logic        psel,               // apb select
  input wire logic        penable,            // apb enable
  input wire logic        pwrite,             // apb write
  input wire logic [7:0]  paddr,              // apb address
  input wire logic        pready,             // apb ready
  input wire logic [31:0] prdata,             // apb read data
  input wire logic        nvm_present_strap,  // eeprom fitted
  input wire logic        eep_cs,             // chip select
  input wire logic        eep_sk,             // serial clock
  input wire logic        eep_di,             // serial data
  input wire logic [15:0] config_word         // config register
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  int hi_cnt;
  int rise_cnt;
  // cycles sk has been high, and sk rises within the current frame
  always_ff @(posedge clk_sys) begin
    hi_cnt   <= eep_sk ? hi_cnt + 1 : 0;
    rise_cnt <= !eep_cs ? 0 : rise_cnt + int'($rose(eep_sk));
  end
  sequence s_busy_rd;
    psel && !penable && !pwrite && eep_cs;
  endsequence
  AST_BOOT_START: assert property ($rose(rst_n) && nvm_present_strap |-> ##[1:200] eep_cs)
    else $error("boot reload did not start");
  AST_NO_NVM: assert property (!nvm_present_strap |-> !eep_cs)
    else $error("eeprom selected while absent");
  AST_SK_IN_FRAME: assert property (eep_sk |-> eep_cs)
    else $error("serial clock outside frame");
  AST_DI_HOLD: assert property (eep_sk && $past(eep_sk) |-> $stable(eep_di))
    else $error("data in moved while clock high");
  AST_SK_HALF: assert property ($fell(eep_sk) |-> hi_cnt == ssl_pkg::SK_HALF_CYC)
    else $error("serial clock high time wrong");
  AST_FRAME_BITS: assert property ($fell(eep_cs) |-> rise_cnt == ssl_pkg::FRAME_BITS || rise_cnt == 0)
    else $error("frame bit count wrong");
  AST_BUSY_CTRL: assert property (s_busy_rd ##0 paddr == ssl_pkg::ADDR_CTRL |=> prdata[2:1] == 2'b11)
    else $error("control not busy during access");
  AST_LOCK_RD: assert property (s_busy_rd ##0 paddr != ssl_pkg::ADDR_CTRL |=> prdata == 32'h00000000)
    else $error("register readable while busy");
  AST_LOCK_WR: assert property (psel && penable && pwrite && eep_cs && paddr == ssl_pkg::ADDR_CONFIG
    |=> $stable(config_word))
    else $error("register written while busy");
endmodule : ssl_loader_chk
bind ssl_loader ssl_loader_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .nvm_present_strap(nvm_present_strap), .eep_cs(eep_cs), .eep_sk(eep_sk), .eep_di(eep_di),
  .config_word(config_word));
`default_nettype wire

// ---- bench/ssl_eep_model.sv ----
// behavioural three-wire serial eeprom
`timescale 1ns/1ps
`default_nettype none
module ssl_eep_model (
  input wire logic cs,      // chip select
  input wire logic sk,      // serial clock
  input wire logic di,      // data in
  output logic     dout     // data out
);
  logic [15:0] mem [64];
  logic [1:0]  op;
  logic [5:0]  a;
  logic [15:0] sh;
  logic        wr_en = 1'b0;
  int          cnt = 0;
  initial begin
    dout = 1'b0;
    for (int i = 0; i < 64; i++) begin
      mem[i] = 16'(i * 263) ^ 16'hB000;
    end
  end
  always @(posedge sk) if (cs) begin
    if (cnt > 0 || di === 1'b1) cnt++;
    if (cnt >= 2 && cnt <= 3) op = {op[0], di};
    else if (cnt >= 4 && cnt <= 9) a = {a[4:0], di};
    else if (cnt >= 10) sh = {sh[14:0], di};
  end
  // read data leads each rising clock; otherwise the line keeps changing
  always @(negedge sk) begin
    if (cs && op == 2'b10 && cnt >= 9 && cnt <= 24) dout = mem[a][24 - cnt];
    else dout = ~dout;
  end
  always @(posedge cs) dout = 1'b1;
  always @(negedge cs) begin
    if (op == 2'b01 && cnt == 25 && wr_en) mem[a] = sh;
    if (op == 2'b00 && cnt >= 9 && a[5:4] == 2'b11) wr_en = 1'b1;
    cnt = 0;
    dout = ~dout;
  end
endmodule : ssl_eep_model
`default_nettype wire

// ---- bench/ssl_loader_tb_top.sv ----
// testbench for the eeprom setup loader
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module ssl_loader_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h00000000;
  logic [2:0]  straps  = 3'h3;
  logic        nvm     = 1'b1;
  logic        pready, pslverr, eep_cs, eep_sk, eep_di, eep_do;
  logic [31:0] prdata, rd;
  logic [15:0] config_word, base_word;
  logic [47:0] station_addr;
  int          error_cnt = 0;
  int          n_checks  = 0;
  always #5 clk_sys = ~clk_sys;
  ssl_loader i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .board_slot_straps(straps), .nvm_present_strap(nvm), .eep_cs(eep_cs),
    .eep_sk(eep_sk), .eep_di(eep_di), .eep_do(eep_do), .config_word(config_word),
    .base_word(base_word), .station_addr(station_addr));
  ssl_eep_model i_eep (.cs(eep_cs), .sk(eep_sk), .di(eep_di), .dout(eep_do));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h00000000);
    `CHK(rd, e)
  endtask : rd_chk
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      xfer(1'b0, ssl_pkg::ADDR_CTRL, 32'h00000000);
      n++;
    end while (rd[2:1] !== 2'b00 && n < 20000);
    `CHK(rd[2:1], 2'b00)
  endtask : wait_idle
  task automatic do_reset(input logic [2:0] s, input logic p);
    @(posedge clk_sys);
    rst_n  <= 1'b0;
    straps <= s;
    nvm    <= p;
    repeat (10) @(posedge clk_sys);
    rst_n  <= 1'b1;
  endtask : do_reset
  task automatic give_verdict;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  initial begin
    #900000;
    error_cnt++;
    give_verdict;
  end
  initial begin
    do_reset(3'h3, 1'b1);
    rd_chk(ssl_pkg::ADDR_CTRL, 32'h00000006);
    rd_chk(ssl_pkg::ADDR_BASE, 32'h00000000);
    wait_idle;
    `CHK(config_word, i_eep.mem[12])
    `CHK(base_word, i_eep.mem[13])
    `CHK(station_addr, {i_eep.mem[34], i_eep.mem[33], i_eep.mem[32]})
    rd_chk(ssl_pkg::ADDR_IA45, {16'h0000, i_eep.mem[34]});
    rd_chk(8'h40, 32'h00000000);
    xfer(1'b1, ssl_pkg::ADDR_PTR, 32'h000000FF);
    xfer(1'b1, ssl_pkg::ADDR_CTRL, 32'h00000003);
    xfer(1'b1, ssl_pkg::ADDR_CONFIG, 32'h0000BEEF);
    rd_chk(ssl_pkg::ADDR_CONFIG, 32'h00000000);
    `CHK(pslverr, 1'b0)
    wait_idle;
    `CHK(config_word, i_eep.mem[12])
    rd_chk(ssl_pkg::ADDR_GPDATA, {16'h0000, i_eep.mem[63]});
    rd_chk(ssl_pkg::ADDR_CTRL, 32'h00000001);
    xfer(1'b1, ssl_pkg::ADDR_GPDATA, 32'h0000A5C3);
    xfer(1'b1, ssl_pkg::ADDR_PTR, 32'h00000005);
    xfer(1'b1, ssl_pkg::ADDR_CTRL, 32'h00000005);
    wait_idle;
    `CHK(i_eep.mem[5], 16'hA5C3)
    xfer(1'b1, ssl_pkg::ADDR_CONFIG, 32'h00001234);
    xfer(1'b1, ssl_pkg::ADDR_BASE, 32'h00005678);
    xfer(1'b1, ssl_pkg::ADDR_CTRL, 32'h00000004);
    wait_idle;
    `CHK(i_eep.mem[12], 16'h1234)
    `CHK(i_eep.mem[13], 16'h5678)
    xfer(1'b1, ssl_pkg::ADDR_CONFIG, 32'h00009999);
    i_eep.mem[32] = 16'h0F0E;
    straps <= 3'h7;
    xfer(1'b1, ssl_pkg::ADDR_CTRL, 32'h00000002);
    wait_idle;
    `CHK(config_word, 16'h9999)
    `CHK(base_word, ssl_pkg::BASE_FIXED)
    `CHK(station_addr[15:0], 16'h0F0E)
    do_reset(3'h3, 1'b0);
    rd_chk(ssl_pkg::ADDR_CTRL, 32'h00000000);
    `CHK(config_word, ssl_pkg::CONFIG_RST)
    `CHK(station_addr, {3{ssl_pkg::IA_RST}})
    xfer(1'b1, ssl_pkg::ADDR_CTRL, 32'h00000002);
    rd_chk(ssl_pkg::ADDR_CTRL, 32'h00000000);
    give_verdict;
  end
endmodule : ssl_loader_tb_top
`default_nettype wire
